// ==== rtl/psts_sequencer.sv ====
// execution controller for the stored-pattern generator
//
// What this block does
// - three modes only: full-rate run, slow continuous trace, single-line step
// - run emits one line per pattern clock period set in the rate register
// - trace advances on a slow internal tick of several hundred milliseconds
// - step executes one line per launch key press, then waits; while waiting only the generator key steps, the system key stops
// - mode selection is run after reset
// - trace stops on any key or after line 2047, raising stopped
// - launch after any stop restarts at the first-line setting
// - step stops at memory end and raises stopped; relaunch uses first line
// - first-line setting takes any absolute line 0 to 2047
// - relative numbering: page A or B plus offset 0 to 1023
// - the executing page is reported read-only
// - generator launch or system launch both start at the first line
// - executed-line counter starts 0, counts lines, wraps to zero after 9999
// - trace and step give per-line readback of count, line, pods, strobes
// - readback line number follows absolute or relative numbering choice
// - tri-stated channel in a pod makes that pod read back as don't-care
// - any tri-stated strobe makes the strobe readback don't-care
// - a stop signals generator-stopped to the display
module psts_sequencer #(
  parameter int unsigned TRACE_CYCLES = psts_pkg::TRACE_CYC
) (
  input  wire logic                    clk,
  input  wire logic                    resetn,
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [7:0]              paddr,
  input  wire logic [31:0]             pwdata,
  output logic [31:0]                  prdata,
  output logic                         pready,
  output logic                         pslverr,
  input  wire logic                    genLaunchKey,
  input  wire logic                    sysLaunchKey,
  input  wire logic                    otherKey,
  output psts_pkg::psts_line_type      patOut,
  output logic                         genStopped,
  output logic                         execPage,
  output logic                         irq
);

  // =====================================================================
  // functions

  // any tri-stated channel per pod byte
  function automatic logic [3:0] podDcOf(input logic [31:0] tri4);
    logic [3:0] dc;
    for (int i = 0; i < 4; i++) begin
      dc[i] = |tri4[i*8 +: 8];
    end
    return dc;
  endfunction

  // next executed-line count with wrap
  function automatic logic [13:0] cntNext(input logic [13:0] c);
    return (c == psts_pkg::CNT_WRAP) ? 14'h0000 : c + 14'h0001;
  endfunction

  // =====================================================================
  // declarations
  psts_pkg::psts_line_type     patMem [psts_pkg::MEM_DEPTH];
  psts_pkg::psts_readback_type rb_r;
  psts_pkg::psts_state_type    state_r;
  psts_pkg::psts_mode_type     mode_r;
  logic                        relNum_r;
  logic [10:0]                 firstLine_r;
  logic [15:0]                 rate_r;
  logic [10:0]                 lineAddr_r;
  logic [10:0]                 execAddr;
  logic [13:0]                 cnt_r;
  logic [13:0]                 cntBase;
  logic [31:0]                 div_r;
  logic [31:0]                 divLimit;
  logic                        tick;
  logic                        execNow;
  logic                        stopNow;
  logic                        launch;
  logic [2:0]                  keyS1_r;
  logic [2:0]                  keyS2_r;
  logic [2:0]                  keyS3_r;
  logic [2:0]                  keyLvl_r;
  logic [2:0]                  keyPress;
  logic [1:0]                  irqStat_r;
  logic [1:0]                  irqEn_r;
  logic [10:0]                 memAddr_r;
  logic [31:0]                 memData_r;
  logic [31:0]                 memTri_r;
  logic                        setup;
  logic                        wrEn;
  logic                        stopEvt;
  logic                        lineEvt;

  // =====================================================================
  // key synchronisers, three stages, change accepted when stages 2 and 3 agree
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      keyS1_r  <= 3'h0;
      keyS2_r  <= 3'h0;
      keyS3_r  <= 3'h0;
      keyLvl_r <= 3'h0;
    end else begin
      keyS1_r <= {otherKey, sysLaunchKey, genLaunchKey};
      keyS2_r <= keyS1_r;
      keyS3_r <= keyS2_r;
      for (int i = 0; i < 3; i++) begin
        if (keyS2_r[i] == keyS3_r[i]) begin
          keyLvl_r[i] <= keyS3_r[i];
        end
      end
    end
  end

  // press pulses from the filtered levels
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      keyPress[i] = keyS2_r[i] & keyS3_r[i] & ~keyLvl_r[i];
    end
  end

  // =====================================================================
  // pattern clock: rate divider in run, slow tick in trace
  assign divLimit = (mode_r == psts_pkg::MODE_TRACE) ? (TRACE_CYCLES - 1)
                                                     : {16'h0000, rate_r};
  assign tick     = (div_r >= divLimit);

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      div_r <= 32'h0000_0000;
    end else if (state_r != psts_pkg::SEQ_EXEC || tick) begin
      div_r <= 32'h0000_0000;
    end else begin
      div_r <= div_r + 32'h0000_0001;
    end
  end

  // =====================================================================
  // sequencing decisions
  assign launch   = keyPress[0] | keyPress[1];
  assign execAddr = (state_r == psts_pkg::SEQ_IDLE) ? firstLine_r
                                                    : lineAddr_r;
  assign cntBase  = (state_r == psts_pkg::SEQ_IDLE) ? 14'h0000 : cnt_r;

  always_comb begin
    execNow = 1'b0;
    stopNow = 1'b0;
    case (state_r)
      psts_pkg::SEQ_IDLE: begin
        execNow = launch && (mode_r == psts_pkg::MODE_STEP);
      end
      psts_pkg::SEQ_EXEC: begin
        stopNow = keyPress[2] | launch;
        execNow = tick && !stopNow;
      end
      psts_pkg::SEQ_WAIT: begin
        stopNow = keyPress[2] | keyPress[1];
        execNow = keyPress[0] && !stopNow;
      end
      default: begin
        stopNow = 1'b1;
      end
    endcase
  end

  // end of memory stops trace and step, run wraps around
  assign stopEvt = stopNow ||
                   (execNow && execAddr == psts_pkg::LAST_LINE &&
                    mode_r != psts_pkg::MODE_RUN);
  assign lineEvt = execNow && mode_r != psts_pkg::MODE_RUN;

  // =====================================================================
  // state machine
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_r <= psts_pkg::SEQ_IDLE;
    end else if (stopEvt) begin
      state_r <= psts_pkg::SEQ_IDLE;
    end else begin
      case (state_r)
        psts_pkg::SEQ_IDLE: begin
          if (launch) begin
            state_r <= (mode_r == psts_pkg::MODE_STEP) ? psts_pkg::SEQ_WAIT
                                                       : psts_pkg::SEQ_EXEC;
          end
        end
        psts_pkg::SEQ_EXEC: begin
          if (mode_r == psts_pkg::MODE_STEP) begin
            state_r <= psts_pkg::SEQ_WAIT;
          end
        end
        psts_pkg::SEQ_WAIT: begin
          if (mode_r != psts_pkg::MODE_STEP) begin
            state_r <= psts_pkg::SEQ_EXEC;
          end
        end
        default: begin
          state_r <= psts_pkg::SEQ_IDLE;
        end
      endcase
    end
  end

  // line address, counter and pod outputs; held while stopped
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      lineAddr_r <= 11'h000;
      cnt_r      <= 14'h0000;
      patOut     <= '0;
      execPage   <= 1'b0;
    end else if (execNow) begin
      patOut     <= patMem[execAddr];
      lineAddr_r <= execAddr + 11'h001;
      cnt_r      <= cntNext(cntBase);
      execPage   <= execAddr[10];
    end else if (state_r == psts_pkg::SEQ_IDLE && launch) begin
      lineAddr_r <= firstLine_r;
      cnt_r      <= 14'h0000;
    end
  end

  // per-line readback in trace and step
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rb_r <= '0;
    end else if (lineEvt) begin
      rb_r.relative <= relNum_r;
      rb_r.line     <= execAddr;
      rb_r.podDc    <= podDcOf(patMem[execAddr].podTri);
      rb_r.strobeDc <= |patMem[execAddr].strobeTri;
      rb_r.strobe   <= patMem[execAddr].strobe;
      rb_r.pods     <= patMem[execAddr].pods;
      rb_r.count    <= cntBase;
    end
  end

  // stopped indication, cleared by the next launch
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      genStopped <= 1'b0;
    end else if (stopEvt) begin
      genStopped <= 1'b1;
    end else if (state_r == psts_pkg::SEQ_IDLE && launch) begin
      genStopped <= 1'b0;
    end
  end

  // =====================================================================
  // apb slave: zero wait, answer in the first access cycle
  assign setup = psel && !penable;
  assign wrEn  = psel && penable && pready && pwrite && !pslverr;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else if (setup) begin
      pready  <= 1'b1;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
      case (paddr)
        psts_pkg::ADDR_CTRL: begin
          prdata[psts_pkg::CTRL_MODE_LSB +: 2]   <= mode_r;
          prdata[psts_pkg::CTRL_REL_BIT]         <= relNum_r;
          prdata[psts_pkg::CTRL_FIRST_LSB +: 11] <= firstLine_r;
        end
        psts_pkg::ADDR_RATE:     prdata[15:0] <= rate_r;
        psts_pkg::ADDR_STATUS:   prdata[2:0]  <= {execPage, genStopped,
                                                  state_r != psts_pkg::SEQ_IDLE};
        psts_pkg::ADDR_COUNT:    prdata[13:0] <= cnt_r;
        psts_pkg::ADDR_RB_INFO:  prdata[21:0] <= {rb_r.strobeDc, rb_r.podDc,
                                                  rb_r.strobe, rb_r.relative,
                                                  1'b0, rb_r.line};
        psts_pkg::ADDR_RB_PODS:  prdata       <= rb_r.pods;
        psts_pkg::ADDR_RB_COUNT: prdata[13:0] <= rb_r.count;
        psts_pkg::ADDR_IRQ_STAT: prdata[1:0]  <= irqStat_r;
        psts_pkg::ADDR_IRQ_EN:   prdata[1:0]  <= irqEn_r;
        psts_pkg::ADDR_MEM_ADDR: prdata[10:0] <= memAddr_r;
        psts_pkg::ADDR_IRQ_CLR, psts_pkg::ADDR_MEM_DATA,
        psts_pkg::ADDR_MEM_TRI, psts_pkg::ADDR_MEM_CTRL: begin
          prdata <= 32'h0000_0000;                   // write-only read as zero
        end
        default: pslverr <= 1'b1;
      endcase
    end else begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // control registers
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      mode_r      <= psts_pkg::MODE_RUN;
      relNum_r    <= 1'b0;
      firstLine_r <= 11'h000;
      rate_r      <= psts_pkg::RATE_RST;
      irqEn_r     <= 2'h0;
    end else if (wrEn) begin
      case (paddr)
        psts_pkg::ADDR_CTRL: begin
          // an unused mode code keeps the previous mode
          if (pwdata[psts_pkg::CTRL_MODE_LSB +: 2] != 2'h3) begin
            mode_r <= psts_pkg::psts_mode_type'(pwdata[psts_pkg::CTRL_MODE_LSB +: 2]);
          end
          relNum_r    <= pwdata[psts_pkg::CTRL_REL_BIT];
          // bit 10 is page b in relative form, offset below it
          firstLine_r <= pwdata[psts_pkg::CTRL_FIRST_LSB +: 11];
        end
        psts_pkg::ADDR_RATE:   rate_r  <= pwdata[15:0];
        psts_pkg::ADDR_IRQ_EN: irqEn_r <= pwdata[1:0];
        default: ;
      endcase
    end
  end

  // pattern memory loading with auto-increment
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      memAddr_r <= 11'h000;
      memData_r <= 32'h0000_0000;
      memTri_r  <= 32'h0000_0000;
    end else if (wrEn) begin
      case (paddr)
        psts_pkg::ADDR_MEM_ADDR: memAddr_r <= pwdata[10:0];
        psts_pkg::ADDR_MEM_DATA: memData_r <= pwdata;
        psts_pkg::ADDR_MEM_TRI:  memTri_r  <= pwdata;
        psts_pkg::ADDR_MEM_CTRL: memAddr_r <= memAddr_r + 11'h001;
        default: ;
      endcase
    end
  end

  // memory array write, commit on the control word
  always_ff @(posedge clk) begin
    if (wrEn && paddr == psts_pkg::ADDR_MEM_CTRL) begin
      patMem[memAddr_r] <= '{pods: memData_r, podTri: memTri_r,
                             strobe: pwdata[3:0], strobeTri: pwdata[7:4]};
    end
  end

  // =====================================================================
  // interrupts: sticky status, set wins over clear
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      irqStat_r <= 2'h0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if ((i == psts_pkg::IRQ_STOP_BIT && stopEvt) ||
            (i == psts_pkg::IRQ_LINE_BIT && lineEvt)) begin
          irqStat_r[i] <= 1'b1;
        end else if (wrEn && paddr == psts_pkg::ADDR_IRQ_CLR && pwdata[i]) begin
          irqStat_r[i] <= 1'b0;
        end
      end
    end
  end

  // level interrupt from enabled status
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irqStat_r & irqEn_r);
    end
  end

endmodule // psts_sequencer

// ==== rtl/psts_pkg.sv ====
// shared constants and types for the pattern sequencer
package psts_pkg;

  // =====================================================================
  // clock and timing
  localparam int unsigned CLK_MHZ        = 200;
  localparam int unsigned TRACE_MS       = 300;   // trace clock period
  localparam int unsigned TRACE_CYC      = TRACE_MS * CLK_MHZ * 1000;

  // =====================================================================
  // sizes and limits
  localparam int unsigned LINE_W         = 11;
  localparam int unsigned MEM_DEPTH      = 2048;
  localparam logic [10:0] LAST_LINE      = 11'h7ff; // line 2047
  localparam logic [13:0] CNT_WRAP       = 14'h270f; // 9999

  // =====================================================================
  // register byte offsets
  localparam logic [7:0] ADDR_CTRL       = 8'h00;
  localparam logic [7:0] ADDR_RATE       = 8'h04;
  localparam logic [7:0] ADDR_STATUS     = 8'h08;
  localparam logic [7:0] ADDR_COUNT      = 8'h0c;
  localparam logic [7:0] ADDR_RB_INFO    = 8'h10;
  localparam logic [7:0] ADDR_RB_PODS    = 8'h14;
  localparam logic [7:0] ADDR_RB_COUNT   = 8'h18;
  localparam logic [7:0] ADDR_IRQ_STAT   = 8'h1c;
  localparam logic [7:0] ADDR_IRQ_CLR    = 8'h20;
  localparam logic [7:0] ADDR_IRQ_EN     = 8'h24;
  localparam logic [7:0] ADDR_MEM_ADDR   = 8'h28;
  localparam logic [7:0] ADDR_MEM_DATA   = 8'h2c;
  localparam logic [7:0] ADDR_MEM_TRI    = 8'h30;
  localparam logic [7:0] ADDR_MEM_CTRL   = 8'h34;

  // =====================================================================
  // field positions
  localparam int unsigned CTRL_MODE_LSB  = 0;    // two bits
  localparam int unsigned CTRL_REL_BIT   = 2;
  localparam int unsigned CTRL_FIRST_LSB = 4;    // eleven bits
  localparam int unsigned IRQ_STOP_BIT   = 0;
  localparam int unsigned IRQ_LINE_BIT   = 1;

  // =====================================================================
  // reset values
  localparam logic [15:0] RATE_RST       = 16'h0000;

  // =====================================================================
  // types
  typedef enum logic [1:0] {
    MODE_RUN   = 2'b00,
    MODE_TRACE = 2'b01,
    MODE_STEP  = 2'b10
  } psts_mode_type;

  typedef enum logic [1:0] {
    SEQ_IDLE = 2'b00,
    SEQ_EXEC = 2'b01,
    SEQ_WAIT = 2'b10
  } psts_state_type;

  typedef struct packed {
    logic [31:0] pods;      // pods d,c,b,a from high byte down
    logic [31:0] podTri;    // per channel tri-state
    logic [3:0]  strobe;
    logic [3:0]  strobeTri;
  } psts_line_type;

  typedef struct packed {
    logic        relative;  // line shown as page and offset
    logic [10:0] line;      // page in bit 10 when relative
    logic [3:0]  podDc;     // per pod don't-care
    logic        strobeDc;
    logic [3:0]  strobe;
    logic [31:0] pods;
    logic [13:0] count;
  } psts_readback_type;

endpackage

// ==== verification/psts_uut_model.sv ====
// probe-pod side of the unit under test: counts lines and shows pin levels
module psts_uut_model (
  input  wire logic                    clk,
  input  wire logic                    resetn,
  input  wire psts_pkg::psts_line_type patOut,
  output int                           seenLines,
  output logic [31:0]                  podPins
);
  timeunit 1ns;
  timeprecision 100ps;

  psts_pkg::psts_line_type lastR;

  // =====================================================================
  // line intake
  // a tri-stated channel floats, so its pin shows the inverse of its last level
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      seenLines <= 0;
      lastR     <= '0;
      podPins   <= 32'h0;
    end else if (patOut !== lastR) begin
      seenLines <= seenLines + 1;
      lastR     <= patOut;
      podPins   <= (patOut.pods & ~patOut.podTri) | (~podPins & patOut.podTri);
    end
  end
endmodule // psts_uut_model

// ==== verification/psts_sequencer_properties.sv ====
// port assertions for the pattern sequencer
module psts_sequencer_properties #(
  parameter int unsigned TRACE_CYCLES = 8
) (
  input wire logic                    clk,
  input wire logic                    resetn,
  input wire logic                    psel,
  input wire logic                    penable,
  input wire logic                    pwrite,
  input wire logic [7:0]              paddr,
  input wire logic [31:0]             pwdata,
  input wire logic [31:0]             prdata,
  input wire logic                    pready,
  input wire logic                    pslverr,
  input wire logic                    genLaunchKey,
  input wire logic                    sysLaunchKey,
  input wire logic                    otherKey,
  input wire psts_pkg::psts_line_type patOut,
  input wire logic                    genStopped,
  input wire logic                    execPage,
  input wire logic                    irq
);
  timeunit 1ns;
  timeprecision 100ps;

  logic [1:0]  modeR;
  logic [15:0] rateR;
  logic [31:0] gapR;
  logic        seenR;
  wire logic   anyKey = genLaunchKey | sysLaunchKey | otherKey;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  // =====================================================================
  // helper: mode and rate as written over the bus
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      modeR <= 2'h0;
      rateR <= 16'h0000;
    end else if (psel && penable && pready && pwrite) begin
      if (paddr == psts_pkg::ADDR_CTRL && pwdata[1:0] != 2'h3) begin
        modeR <= pwdata[1:0];
      end
      if (paddr == psts_pkg::ADDR_RATE) begin
        rateR <= pwdata[15:0];
      end
    end
  end

  // helper: cycles since last line, cleared flag after a key
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      gapR  <= 32'h0;
      seenR <= 1'b0;
    end else if ($changed(patOut)) begin
      gapR  <= 32'h0;
      seenR <= 1'b1;
    end else begin
      gapR  <= gapR + 32'h1;
      seenR <= seenR & ~anyKey;
    end
  end

  // =====================================================================
  // assertions
  run_gap_a: assert property (
    modeR == psts_pkg::MODE_RUN && seenR && $changed(patOut) |-> gapR >= 32'(rateR))
    else $error("run lines too close");
  trace_gap_a: assert property (
    modeR == psts_pkg::MODE_TRACE && seenR && $changed(patOut) |-> gapR == TRACE_CYCLES - 1)
    else $error("trace line spacing wrong");
  step_press_a: assert property (
    modeR == psts_pkg::MODE_STEP && $changed(patOut) |->
      $past(genLaunchKey, 2) || $past(sysLaunchKey, 2))
    else $error("step line without a key press");
  step_wait_a: assert property (
    modeR == psts_pkg::MODE_STEP && $changed(patOut) |=> $stable(patOut) [*6])
    else $error("step ran past one line");
  stop_hold_a: assert property (
    (genStopped && !(genLaunchKey || sysLaunchKey)) [*4] |=> $stable(patOut))
    else $error("pattern moved while stopped");
  stop_cause_a: assert property (
    $rose(genStopped) |-> $changed(patOut) || gapR == 32'h0 || $past(anyKey, 2))
    else $error("stop without key or end line");
  pready_once_a: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  setup_ans_a: assert property (psel && !penable |=> pready)
    else $error("no answer in first access cycle");
  unmapped_a: assert property (
    pready && paddr > psts_pkg::ADDR_MEM_CTRL |-> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
endmodule // psts_sequencer_properties

// ==== verification/tb.sv ====
// self-checking bench for the pattern sequencer
module tb;
  timeunit 1ns;
  timeprecision 100ps;

  localparam int unsigned TRC = 8;
  logic                    clk;
  logic                    resetn;
  logic                    psel;
  logic                    penable;
  logic                    pwrite;
  logic [7:0]              paddr;
  logic [31:0]             pwdata;
  logic [31:0]             prdata;
  logic                    pready;
  logic                    pslverr;
  logic [2:0]              keys;
  psts_pkg::psts_line_type patOut;
  logic                    genStopped;
  logic                    execPage;
  logic                    irq;
  int                      seenLines;
  logic [31:0]             podPins;
  int                      mismatches = 0;
  int                      totalChecks = 0;
  logic [31:0]             seed = 32'h2e5be3c8;
  logic                    watchPat = 1'b0;
  psts_pkg::psts_line_type lastPat = '0;
  psts_pkg::psts_line_type memE [2048];
  psts_pkg::psts_line_type patQ [$];
  logic [32:0]             rdQ [$];

  psts_sequencer #(.TRACE_CYCLES(TRC)) u_psts_sequencer (
    .clk(clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .genLaunchKey(keys[0]), .sysLaunchKey(keys[1]), .otherKey(keys[2]),
    .patOut(patOut), .genStopped(genStopped), .execPage(execPage), .irq(irq));
  psts_uut_model u_psts_uut_model (
    .clk(clk), .resetn(resetn), .patOut(patOut), .seenLines(seenLines), .podPins(podPins));

  always #2.5 clk = ~clk;

  // =====================================================================
  // helpers
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // expected readback word: line, form, strobe, don't-care flags
  function automatic logic [31:0] rbi(logic [10:0] ln, logic rel, psts_pkg::psts_line_type v);
    return {10'h0, |v.strobeTri, |v.podTri[31:24], |v.podTri[23:16], |v.podTri[15:8],
            |v.podTri[7:0], v.strobe, rel, 1'b0, ln};
  endfunction

  task automatic cmp(input string nm, input logic [71:0] e, input logic [71:0] g);
    totalChecks++;
    if (g !== e) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", totalChecks, mismatches);
    if (mismatches == 0 && totalChecks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // one apb transfer, held until pready is sampled high
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    int n;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      mismatches++;
      summarize();
    end
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic err = 1'b0);
    rdQ.push_back({err, e});
    bus(a, 1'b0, 32'h0);
  endtask

  task automatic press(input int k);
    keys[k] <= 1'b1;
    repeat (8) @(posedge clk);
    keys[k] <= 1'b0;
    repeat (8) @(posedge clk);
  endtask

  task automatic expLine(input logic [10:0] ln, input int k);
    patQ.push_back(memE[ln]);
    press(k);
  endtask

  // s holds strobe tri in the high nibble, strobe in the low one
  task automatic load(input logic [10:0] ln, input logic [31:0] t, input logic [7:0] s);
    memE[ln] = '{rnd(), t, s[3:0], s[7:4]};
    bus(psts_pkg::ADDR_MEM_ADDR, 1'b1, {21'h0, ln});
    bus(psts_pkg::ADDR_MEM_DATA, 1'b1, memE[ln].pods);
    bus(psts_pkg::ADDR_MEM_TRI, 1'b1, t);
    bus(psts_pkg::ADDR_MEM_CTRL, 1'b1, {24'h0, s});
  endtask

  // =====================================================================
  // result watcher: oldest note against what appears
  always @(posedge clk) begin
    if (psel && penable && pready && !pwrite) begin
      cmp("read", 72'(rdQ.pop_front()), 72'({pslverr, prdata}));
    end
    if (watchPat && patOut !== lastPat) begin
      cmp("pattern", patQ.pop_front(), patOut);
    end
    lastPat = patOut;
  end

  // =====================================================================
  // main sequence
  initial begin
    int n;
    int n0;
    clk     = 1'b0;
    resetn  = 1'b0;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h0;
    keys    = 3'h0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    rd(psts_pkg::ADDR_CTRL, 32'h0);
    rd(psts_pkg::ADDR_STATUS, 32'h0);
    rd(8'h3c, 32'h0, 1'b1);
    load(11'h000, 32'h0, 8'h05);
    load(11'h001, 32'h0004_0000, 8'h20);
    load(11'h7fd, 32'h0, 8'h0a);
    load(11'h7fe, 32'h0, 8'h03);
    load(11'h7ff, 32'h0, 8'h0c);
    // step from absolute line 0
    watchPat = 1'b1;
    bus(psts_pkg::ADDR_CTRL, 1'b1, 32'h0000_0002);
    expLine(11'h000, 0);
    cmp("pins", 72'(memE[0].pods), 72'(podPins));
    rd(psts_pkg::ADDR_RB_COUNT, 32'h0);
    rd(psts_pkg::ADDR_RB_INFO, rbi(11'h000, 1'b0, memE[0]));
    expLine(11'h001, 0);
    rd(psts_pkg::ADDR_RB_COUNT, 32'h1);
    rd(psts_pkg::ADDR_RB_INFO, rbi(11'h001, 1'b0, memE[1]));
    press(2);
    rd(psts_pkg::ADDR_STATUS, 32'h2);
    expLine(11'h000, 0);
    rd(psts_pkg::ADDR_RB_COUNT, 32'h0);
    // step in relative numbering, page b to memory end
    press(2);
    bus(psts_pkg::ADDR_CTRL, 1'b1, 32'h0000_7fe6);
    expLine(11'h7fe, 0);
    rd(psts_pkg::ADDR_RB_INFO, rbi(11'h7fe, 1'b1, memE[2046]));
    cmp("page", 72'h1, 72'(execPage));
    bus(psts_pkg::ADDR_IRQ_CLR, 1'b1, 32'h3);
    expLine(11'h7ff, 0);
    rd(psts_pkg::ADDR_STATUS, 32'h6);
    rd(psts_pkg::ADDR_IRQ_STAT, 32'h3);
    cmp("irq masked", 72'h0, 72'(irq));
    bus(psts_pkg::ADDR_IRQ_EN, 1'b1, 32'h1);
    @(posedge clk);
    cmp("irq", 72'h1, 72'(irq));
    bus(psts_pkg::ADDR_IRQ_CLR, 1'b1, 32'h1);
    @(posedge clk);
    cmp("irq cleared", 72'h0, 72'(irq));
    rd(psts_pkg::ADDR_IRQ_STAT, 32'h2);
    // trace from absolute 2045, launched by the system key
    bus(psts_pkg::ADDR_CTRL, 1'b1, 32'h0000_7fd1);
    n0 = seenLines;
    patQ.push_back(memE[2045]);
    patQ.push_back(memE[2046]);
    expLine(11'h7ff, 1);
    n = 0;
    while (genStopped !== 1'b1 && n < 500) begin
      @(posedge clk);
      n++;
    end
    if (n >= 500) begin
      mismatches++;
      summarize();
    end
    @(posedge clk);
    cmp("trace lines", 72'(n0 + 3), 72'(seenLines));
    rd(psts_pkg::ADDR_STATUS, 32'h6);
    // run from 2045 across the wrap, stopped by another key
    watchPat = 1'b0;
    bus(psts_pkg::ADDR_RATE, 1'b1, 32'h3);
    bus(psts_pkg::ADDR_CTRL, 1'b1, 32'h0000_7fd0);
    bus(psts_pkg::ADDR_CTRL, 1'b1, 32'h7fd3);
    rd(psts_pkg::ADDR_CTRL, 32'h7fd0);
    press(0);
    repeat (4) @(posedge clk);
    press(2);
    cmp("stopped", 72'h1, 72'(genStopped));
    cmp("wrap", 72'h0, 72'(execPage));
    repeat (20) @(posedge clk);
    summarize();
  end
endmodule // tb

bind psts_sequencer psts_sequencer_properties #(.TRACE_CYCLES(TRACE_CYCLES))
  u_psts_sequencer_properties (
  .clk(clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .genLaunchKey(genLaunchKey), .sysLaunchKey(sysLaunchKey), .otherKey(otherKey),
  .patOut(patOut), .genStopped(genStopped), .execPage(execPage), .irq(irq));
